/* File: verilog/rcod_pkg.sv */
package rcod_pkg;
	// Register byte addresses on the AXI4-Lite bus.
	localparam int unsigned    ADDR_W      = 4;
	localparam logic [3:0]     CTRL_ADDR   = 4'h0;
	localparam logic [3:0]     STAT_ADDR   = 4'h4;
	// Control register field positions and reset value.
	localparam int unsigned    EN_BIT      = 15;
	localparam int unsigned    SLP_BIT     = 13;
	localparam int unsigned    SEL_BIT     = 12;
	localparam int unsigned    DIV_LSB     = 8;
	localparam int unsigned    DIV_W       = 4;
	localparam logic [15:0]    CTRL_MASK   = 16'hbf00;
	localparam logic [15:0]    CTRL_RESET  = 16'h0000;
	// Status register field positions.
	localparam int unsigned    ST_OUT_BIT  = 15;
	localparam int unsigned    ST_RUN_BIT  = 14;
	localparam int unsigned    ST_PD_BIT   = 13;
	localparam int unsigned    ST_SEL_BIT  = 12;
	localparam int unsigned    ST_DIV_LSB  = 8;
	// Divider counter width covers a ratio of up to 32768.
	localparam int unsigned    CNT_W       = 15;
	localparam logic [3:0]     DIV_PASS    = 4'h0;
	// AXI response codes.
	localparam logic [1:0]     RESP_OKAY   = 2'h0;
	localparam logic [1:0]     RESP_SLVERR = 2'h2;

	// Requests driven by the bus master.
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} rcod_axil_req_t;

	// Answers driven by this slave.
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} rcod_axil_rsp_t;

	// Clock inputs and power state seen by the generator.
	typedef struct packed {
		logic       posc_level;
		logic       sysclk_level;
		logic [2:0] current_clock_source;
		logic       primary_osc_sleep_enable;
		logic       sleep;
	} rcod_clk_in_t;
endpackage

/* File: verilog/rcod_top.sv */
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
module rcod_top (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire rcod_pkg::rcod_axil_req_t axi_req,
	output      rcod_pkg::rcod_axil_rsp_t axi_rsp,
	input  wire rcod_pkg::rcod_clk_in_t  clk_in,
	output logic                         reference_output_pin,
	output logic                         posc_power_down
);
	import rcod_pkg::*;

	// The whole state of the block in one record.
	typedef struct packed {
		logic [15:0]       ctrl;      // Software control word.
		logic              act_sel;   // Source in use by the divider.
		logic [3:0]        act_div;   // Ratio exponent in use.
		logic [2:0]        act_cur;   // System source seen at last load.
		logic [CNT_W-1:0]  cnt;       // Source edge counter.
		logic              src_prev;  // Source level one cycle ago.
		logic              out;       // Reference output level.
		logic              pd;        // Oscillator power-down request.
		logic              running;   // Generator is producing a clock.
		logic              awready;   // Write address may be taken.
		logic              wready;    // Write data may be taken.
		logic              aw_have;   // Write address held.
		logic [ADDR_W-1:0] aw_addr;   // Held write address.
		logic              w_have;    // Write data held.
		logic [31:0]       wdata;     // Held write data.
		logic [3:0]        wstrb;     // Held byte strobes.
		logic              bvalid;    // Write answer pending.
		logic [1:0]        bresp;     // Write answer code.
		logic              arready;   // Read address may be taken.
		logic              rvalid;    // Read answer pending.
		logic [31:0]       rdata;     // Read answer data.
		logic [1:0]        rresp;     // Read answer code.
	} rcod_state_t;

	rcod_state_t st_reg;   // Registered state.
	rcod_state_t st_next;  // Next state.

	// Mask of counter bits that belong to a ratio of two to the n.
	function automatic logic [CNT_W-1:0] div_mask(input logic [3:0] n);
		logic [CNT_W:0] full;
		full = (CNT_W+1)'(1) << n;
		div_mask = CNT_W'(full - (CNT_W+1)'(1));
	endfunction

	logic src;       // Level of the source the divider uses.
	logic src_rise;  // Rising edge of that source.
	logic keep_slp;  // All three conditions for running in sleep.
	logic run;       // Generator allowed to run this cycle.

	// Source choice, edge detect and sleep gating.
	always_comb begin
		// The active select, not the control bit, picks the source, so a
		// new choice only takes effect at a period boundary.
		src = st_reg.act_sel ?
			clk_in.posc_level : clk_in.sysclk_level;
		src_rise = src & ~st_reg.src_prev;
		// Sleep gating does not look at which mode clocks the system.
		keep_slp = st_reg.ctrl[SLP_BIT] & st_reg.ctrl[SEL_BIT] &
			clk_in.primary_osc_sleep_enable;
		run = st_reg.ctrl[EN_BIT] &
			(~clk_in.sleep | keep_slp);
	end

	// Next-state logic for the generator and the bus slave.
	always_comb begin
		st_next = st_reg;
		st_next.src_prev = src;
		st_next.running = run;
		st_next.pd = clk_in.sleep & ~keep_slp;
		if (!run) begin
			// Held low and reset so that enabling starts a whole period.
			st_next.cnt = '0;
			st_next.out = 1'b0;
			st_next.act_sel = st_reg.ctrl[SEL_BIT];
			st_next.act_div = st_reg.ctrl[DIV_LSB +: DIV_W];
			st_next.act_cur = clk_in.current_clock_source;
		end else begin
			// New settings are taken only in the low phase at a period
			// boundary; this costs up to one period of latency but never
			// cuts a pulse short.
			if (!st_reg.out && st_reg.cnt == '0 &&
			    (st_reg.act_sel != st_reg.ctrl[SEL_BIT] ||
			     st_reg.act_div != st_reg.ctrl[DIV_LSB +: DIV_W] ||
			     st_reg.act_cur != clk_in.current_clock_source)) begin
				st_next.act_sel = st_reg.ctrl[SEL_BIT];
				st_next.act_div = st_reg.ctrl[DIV_LSB +: DIV_W];
				st_next.act_cur = clk_in.current_clock_source;
			end else if (st_reg.act_div == DIV_PASS) begin
				// Ratio one passes the source through.
				st_next.out = src;
			end else if (src_rise) begin
				// The top bit of the masked count is the divided clock.
				st_next.cnt = (st_reg.cnt + CNT_W'(1)) &
					div_mask(st_reg.act_div);
				st_next.out = st_next.cnt[st_reg.act_div - 4'h1];
			end
		end

		// Write address and data are taken in either order.
		if (axi_req.awvalid && st_reg.awready) begin
			st_next.aw_have = 1'b1;
			st_next.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && st_reg.wready) begin
			st_next.w_have = 1'b1;
			st_next.wdata = axi_req.wdata;
			st_next.wstrb = axi_req.wstrb;
		end
		if (st_reg.bvalid && axi_req.bready) begin
			st_next.bvalid = 1'b0;
		end
		// Both halves present and no answer pending: perform the write.
		if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
			st_next.bvalid = 1'b1;
			if (st_reg.aw_addr == CTRL_ADDR) begin
				st_next.bresp = RESP_OKAY;
				// Only the upper byte holds bits; the lower reads zero.
				if (st_reg.wstrb[1]) begin
					st_next.ctrl = {st_reg.wdata[15:8], 8'h00} & CTRL_MASK;
				end
			end else if (st_reg.aw_addr == STAT_ADDR) begin
				st_next.bresp = RESP_OKAY;  // Status is read only.
			end else begin
				st_next.bresp = RESP_SLVERR;  // Unmapped address.
			end
		end
		st_next.awready = ~st_next.aw_have;
		st_next.wready = ~st_next.w_have;

		// Read channel: one read in flight at a time.
		if (st_reg.rvalid && axi_req.rready) begin
			st_next.rvalid = 1'b0;
		end
		if (axi_req.arvalid && st_reg.arready) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = RESP_OKAY;
			st_next.rdata = 32'h0000_0000;
			if (axi_req.araddr == CTRL_ADDR) begin
				st_next.rdata[15:0] = st_reg.ctrl;
			end else if (axi_req.araddr == STAT_ADDR) begin
				st_next.rdata[ST_OUT_BIT] = st_reg.out;
				st_next.rdata[ST_RUN_BIT] = st_reg.running;
				st_next.rdata[ST_PD_BIT] = st_reg.pd;
				st_next.rdata[ST_SEL_BIT] = st_reg.act_sel;
				st_next.rdata[ST_DIV_LSB +: DIV_W] = st_reg.act_div;
				st_next.rdata[2:0] = st_reg.act_cur;
			end else begin
				st_next.rresp = RESP_SLVERR;  // Unmapped address.
			end
		end
		st_next.arready = ~st_next.rvalid;
	end

	// State register with synchronous reset.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.ctrl <= CTRL_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the state register; the bus answer is
	// gathered in one assignment so that it has a single driver.
	assign reference_output_pin = st_reg.out;
	assign posc_power_down = st_reg.pd;
	assign axi_rsp = '{
		awready: st_reg.awready,
		wready:  st_reg.wready,
		bvalid:  st_reg.bvalid,
		bresp:   st_reg.bresp,
		arready: st_reg.arready,
		rvalid:  st_reg.rvalid,
		rdata:   st_reg.rdata,
		rresp:   st_reg.rresp
	};

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// A stopped generator leaves the pin low from the next cycle; only a
	// restart in that next cycle may raise it one cycle later.
	a_out_off_low: assert property (
		!run |=> !reference_output_pin ##1
		(!reference_output_pin || $past(run)))
		else $error("output not low while stopped");
	// The first running cycle starts from a low, cleared divider.
	a_enable_starts_low: assert property (
		$rose(run) |-> !st_reg.out && st_reg.cnt == '0)
		else $error("enable began mid period");
	// In divide mode the output moves only on a source rising edge.
	a_div_edge_only: assert property (
		st_reg.running && $past(st_reg.running) &&
		st_reg.act_div != DIV_PASS && $changed(st_reg.out)
		|-> $past(src_rise))
		else $error("divided output moved off edge");
	// Ratio one tracks the source level with one cycle delay; a cycle
	// that loads new settings holds the output and is left out.
	a_pass_through: assert property (
		run && st_reg.act_div == DIV_PASS && $stable(st_reg.act_div)
		##1 run && $stable(st_reg.act_div) &&
		$stable(st_reg.act_sel) && $stable(st_reg.act_cur)
		|-> st_reg.out == $past(src))
		else $error("pass through lost");
	// Settings change only while the output is low.
	a_switch_low: assert property (
		st_reg.running && $past(st_reg.running) &&
		($changed(st_reg.act_sel) || $changed(st_reg.act_cur) ||
		$changed(st_reg.act_div))
		|-> !$past(st_reg.out))
		else $error("switch during high phase");
	// The count never leaves the range of the active ratio.
	a_cnt_range: assert property (
		st_reg.running |-> (st_reg.cnt & ~div_mask(st_reg.act_div)) == '0)
		else $error("count out of range");
	// A control write lands in the next cycle, with its answer.
	a_ctrl_write: assert property (
		st_reg.aw_have && st_reg.w_have && !st_reg.bvalid &&
		st_reg.aw_addr == CTRL_ADDR && st_reg.wstrb[1]
		|=> st_reg.ctrl == ($past(st_reg.wdata[15:0]) & 16'hff00 &
		CTRL_MASK) && st_reg.bvalid)
		else $error("control write lost");
	// Missing sleep conditions power the oscillator down and stop output.
	a_sleep_stop: assert property (
		clk_in.sleep && !keep_slp |=>
		(posc_power_down ##1 !reference_output_pin) or
		(!clk_in.sleep || keep_slp))
		else $error("sleep did not stop");
	// All three conditions keep the generator running in sleep.
	a_sleep_run: assert property (
		clk_in.sleep && keep_slp && st_reg.ctrl[EN_BIT]
		|=> st_reg.running && !posc_power_down)
		else $error("sleep run failed");
	// A stopped generator takes the select bit as software left it.
	a_source_sel: assert property (
		!run |=> st_reg.act_sel == $past(st_reg.ctrl[SEL_BIT]))
		else $error("wrong source");
endmodule

/* File: tb/rcod_ext_model.sv */
// Free-running clock sources plus external logic that times the output.
module rcod_ext_model (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic ref_pin,
	output logic      posc_level,
	output logic      sysclk_level,
	output int        ref_period,
	output int        rise_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	int   pc;   // Oscillator half-period counter.
	int   sc;   // System clock half-period counter.
	int   age;  // Cycles since the last rising edge of the output.
	logic last; // Output level one cycle ago.
	// Sources start low so the block never sees an unknown level.
	initial begin
		posc_level = 1'b0;
		sysclk_level = 1'b0;
	end
	// Oscillator period is 4 cycles, system clock period 6 cycles.
	always @(posedge sys_clk) begin
		pc <= (pc == 1) ? 0 : pc + 1;
		sc <= (sc == 2) ? 0 : sc + 1;
		if (pc == 1)
			posc_level <= !posc_level;
		if (sc == 2)
			sysclk_level <= !sysclk_level;
		last <= ref_pin;
		age <= (ref_pin && !last) ? 1 : age + 1;
		// A rise closes one period; the first one is partial, so chk_period waits for three rises.
		if (!rst && ref_pin && !last) begin
			ref_period <= age;
			rise_cnt <= rise_cnt + 1;
		end
	end
endmodule

/* File: tb/reference_clock_output_divider_bench.sv */
module reference_clock_output_divider_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import rcod_pkg::*;
	logic           sys_clk = 1'b0;
	logic           rst = 1'b1;
	rcod_axil_req_t req = '0;
	rcod_axil_rsp_t rsp;
	rcod_clk_in_t   cin;
	logic [2:0]     cur_src = 3'h0;
	logic           pse = 1'b0;
	logic           sleep = 1'b0;
	logic           posc, sysc, pin, pd;
	int             ref_period, rise_cnt, err_total, samples_checked;
	logic [31:0]    rd;
	logic [1:0]     rs;
	assign cin = {posc, sysc, cur_src, pse, sleep};
	always #25 sys_clk = !sys_clk;
	rcod_top u_dut (.sys_clk(sys_clk), .rst(rst), .axi_req(req),
		.axi_rsp(rsp), .clk_in(cin), .reference_output_pin(pin),
		.posc_power_down(pd));
	rcod_ext_model u_ext (.sys_clk(sys_clk), .rst(rst), .ref_pin(pin),
		.posc_level(posc), .sysclk_level(sysc), .ref_period(ref_period),
		.rise_cnt(rise_cnt));
	task end_of_test;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask
	// A wait that runs out counts as a mismatch and ends the run.
	task hang(input string w);
		err_total++;
		$display("[ERR] %0t timeout in %s", $time, w);
		end_of_test;
	endtask
	// Write: address and data offered together, each dropped once taken.
	task wr(input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge sys_clk);
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				rs = rsp.bresp;
				break;
			end
		end
		req.bready <= 1'b0;
		if (i == 100)
			hang("write");
	endtask
	task rd32(input logic [3:0] a);
		int i;
		@(posedge sys_clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge sys_clk);
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				rd = rsp.rdata;
				rs = rsp.rresp;
				break;
			end
		end
		req.rready <= 1'b0;
		if (i == 100)
			hang("read");
	endtask
	// Three rises make sure the measured period is a whole new one.
	task chk_period(input int exp);
		int i, c0;
		c0 = rise_cnt;
		for (i = 0; i < 5000 && rise_cnt < c0 + 3; i++)
			@(posedge sys_clk);
		if (i == 5000)
			hang("period");
		chk(ref_period, exp, "period");
	endtask
	task t_regs;
		rd32(CTRL_ADDR);
		chk(rd, 32'h0, "ctrl reset");
		chk(rs, RESP_OKAY, "read answer");
		wr(CTRL_ADDR, 32'hffff_ffff);
		chk(rs, RESP_OKAY, "write answer");
		rd32(CTRL_ADDR);
		chk(rd, {16'h0, CTRL_MASK}, "ctrl bits");
		wr(CTRL_ADDR, 32'h0);
		rd32(4'h8);
		chk(rs, RESP_SLVERR, "unmapped read");
		chk(rd, 32'h0, "unmapped data");
		wr(4'h8, 32'h1);
		chk(rs, RESP_SLVERR, "unmapped write");
		$display("registers done");
	endtask
	task t_off;
		int c0;
		c0 = rise_cnt;
		repeat (64) @(posedge sys_clk);
		chk(rise_cnt, c0, "disabled rises");
		chk(pin, 1'b0, "disabled level");
		$display("disabled done");
	endtask
	// Oscillator source, period 4 cycles, divided by two to the n.
	task t_div;
		for (int n = 0; n < 5; n++) begin
			wr(CTRL_ADDR, 32'h0);
			wr(CTRL_ADDR, 32'h9000 | (n << 8));
			chk_period(4 << n);
		end
		$display("divider done");
	endtask
	// System clock source, period 6 cycles; live changes need no disable.
	task t_sys;
		wr(CTRL_ADDR, 32'h8200);
		chk_period(24);
		@(posedge sys_clk);
		cur_src <= 3'h5;
		chk_period(24);
		rd32(STAT_ADDR);
		chk(rd[2:0], 3'h5, "source status");
		chk(rd[ST_RUN_BIT], 1'b1, "status running");
		chk(rd[ST_SEL_BIT], 1'b0, "status select");
		chk(rd[ST_DIV_LSB +: DIV_W], 4'h2, "status divider");
		wr(CTRL_ADDR, 32'h8300);
		chk_period(48);
		$display("system source done");
	endtask
	task t_sleep;
		int c0;
		wr(CTRL_ADDR, 32'hb100);
		@(posedge sys_clk);
		pse <= 1'b1;
		sleep <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk(pd, 1'b0, "kept awake");
		chk_period(8);
		pse <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk(pd, 1'b1, "power down");
		rd32(STAT_ADDR);
		chk(rd[ST_PD_BIT], 1'b1, "status power down");
		chk(rd[ST_RUN_BIT], 1'b0, "status stopped");
		c0 = rise_cnt;
		repeat (64) @(posedge sys_clk);
		chk(rise_cnt, c0, "stopped in sleep");
		sleep <= 1'b0;
		$display("sleep done");
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_off;
		t_div;
		t_sys;
		t_sleep;
		end_of_test;
	end
endmodule
